// ---- src/cal_enh_pkg.sv ----
// Purpose: Shared constants for the calibration and enhancement registers
// Assumes: 8-bit register port, 20 MHz clock
// Notes:   Offsets are the byte addresses of the register port
package cal_enh_pkg;
  localparam logic [7:0] ADDR_MON_OFS     = 8'h67;
  localparam logic [7:0] ADDR_ANA_TRIM    = 8'h68;
  localparam logic [7:0] ADDR_DAC_OFS     = 8'h69;
  localparam logic [7:0] ADDR_CM_BAL      = 8'h6a;
  localparam logic [7:0] ADDR_PEAK_MON    = 8'h6b;
  localparam logic [7:0] ADDR_ENH_EN      = 8'h6c;
  localparam logic [7:0] RST_MON_OFS      = 8'h88;
  localparam logic [7:0] RST_ANA_TRIM     = 8'h00;
  localparam logic [7:0] RST_DAC_OFS      = 8'h00;
  localparam logic [7:0] RST_CM_BAL       = 8'h20;
  localparam logic [7:0] RST_PEAK_MON     = 8'h08;
  localparam logic [7:0] RST_ENH_EN       = 8'h00;
  localparam logic [7:0] MASK_ANA_TRIM    = 8'h0f;
  localparam logic [7:0] MASK_CM_BAL      = 8'h3f;
  localparam logic [7:0] MASK_PEAK_MON    = 8'h0f;
  // Enhancement bit positions
  localparam int BIT_PROGRAMMED_CURRENT_LIMIT_BOOST  = 7;
  localparam int BIT_FSK         = 6;
  localparam int BIT_SPEEDUP     = 5;
  localparam int BIT_ZREF        = 4;
  localparam int BIT_BATTERY_SWITCH_DEBOUNCE        = 3;
  localparam int BIT_LCV         = 2;
  localparam int BIT_SQUELCH     = 1;
  localparam int BIT_HYST        = 0;
  // Boosted loop current limit code, in mA
  localparam logic [5:0] BOOST_LIMIT_MA = 6'h29;
  // Tone rates
  localparam int CLK_HZ          = 20000000;
  localparam int TONE_FAST_HZ    = 24000;
  localparam int TONE_SLOW_HZ    = 8000;
  localparam int TONE_FAST_DIV   = CLK_HZ / TONE_FAST_HZ;
  localparam int TONE_SLOW_DIV   = CLK_HZ / TONE_SLOW_HZ;
  // Battery switch debounce
  localparam int DEBOUNCE_MS     = 60;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
endpackage

// ---- src/tone_rate_gen.sv ----
// Purpose: Tone generator 1 clock enable, 24 kHz or 8 kHz
// Assumes: Single clk domain
// Notes:   Rate change restarts the divider to avoid a long first period
module tone_rate_gen
  import cal_enh_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic fast,
  // Output
  output logic      tick
);
  logic [11:0] count;
  logic        fast_q;
  logic [11:0] limit;

  // The slow divide is above 2047, so the counter needs twelve bits
  assign limit = fast ? 12'(TONE_FAST_DIV - 1) : 12'(TONE_SLOW_DIV - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      count  <= 12'h000;
      fast_q <= 1'b0;
      tick   <= 1'b0;
    end else begin
      fast_q <= fast;
      if (fast != fast_q || count >= limit) begin
        count <= 12'h000;
      end else begin
        count <= count + 12'h001;
      end
      tick <= (fast == fast_q) && (count == limit);
    end
  end
endmodule

// ---- src/calibration_enhancement_regs.sv ----
// Purpose: Calibration results and enhancement enable register group
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Analog functions steered by these bits sit outside
// Behaviour
// - Monitor offset register holds two 4-bit results, upper and lower.
// - Analog trim register has DAC/ADC positive/negative trim bits 3..0.
// - DAC offset register holds full 8-bit result.
// - Balance register holds 6 bits; bits 7:6 read zero.
// - Peak monitor register holds 4 bits; bits 7:4 read zero.
// - Boost bit raises loop current limit to 41 mA after ring burst.
// - Tone 1 clocked at 24 kHz with FSK and release, else 8 kHz.
// - FSK with release selects dedicated FSK oscillator parameters.
// - At 24 kHz oscillator timers step in 41.67 us units.
// - Speedup bit selects multi-threshold converter control.
// - Reference disable bit removes internal impedance resistor.
// - Debounce high-to-low battery switch 60 ms with external batteries, only when HAS_DCDC is clear.
// - Loop closure from voltage when set, from current when clear.
// - Squelch bit suppresses converter loop audio noise.
// - Hysteresis bit enables two-threshold loop closure detection.
// - Enhancement register exists from revision C; resets to zero.
module calibration_enhancement_regs
  import cal_enh_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter bit HAS_ENH      = 1'b1,
  parameter bit HAS_DCDC     = 1'b1
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Analog and feature inputs
  input  wire logic       ring_burst_end,
  input  wire logic       ring_active,
  input  wire logic [5:0] programmed_current_limit,
  input  wire logic       tone_release,
  input  wire logic       external_battery_select,
  input  wire logic       battery_high_req,
  // Calibration values
  output logic      [3:0] monitor_offset_result_a,
  output logic      [3:0] monitor_offset_result_b,
  output logic            dac_pos_trim,
  output logic            dac_neg_trim,
  output logic            adc_pos_trim,
  output logic            adc_neg_trim,
  output logic      [7:0] dac_offset_value,
  output logic      [5:0] balance_result,
  output logic      [3:0] peak_monitor_result,
  // Feature controls
  output logic      [5:0] active_current_limit,
  output logic            tone1_tick,
  output logic            tone1_fast,
  output logic            tone1_oscillator_fsk_sel,
  output logic            converter_speedup,
  output logic            impedance_ref_disable,
  output logic            voltage_loop_closure,
  output logic            converter_squelch,
  output logic            closure_hysteresis_on,
  output logic            battery_high_sel
);
  logic [7:0] mon_ofs;
  logic [7:0] ana_trim;
  logic [7:0] dac_ofs;
  logic [7:0] cm_bal;
  logic [7:0] peak_mon;
  logic [7:0] enh;
  logic       boost_on;
  logic [7:0] next_rdata;
  logic       bat_s1;
  logic       bat_s2;
  logic       rel_s1;
  logic       rel_s2;
  logic       ext_s1;
  logic       ext_s2;
  logic [20:0] deb_count;

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      mon_ofs  <= RST_MON_OFS;
      ana_trim <= RST_ANA_TRIM;
      dac_ofs  <= RST_DAC_OFS;
      cm_bal   <= RST_CM_BAL;
      peak_mon <= RST_PEAK_MON;
      enh      <= RST_ENH_EN;
    end else if (wr) begin
      unique case (addr)
        ADDR_MON_OFS:  mon_ofs  <= wdata;
        ADDR_ANA_TRIM: ana_trim <= wdata & MASK_ANA_TRIM;
        ADDR_DAC_OFS:  dac_ofs  <= wdata;
        ADDR_CM_BAL:   cm_bal   <= wdata & MASK_CM_BAL;
        ADDR_PEAK_MON: peak_mon <= wdata & MASK_PEAK_MON;
        ADDR_ENH_EN: begin
          // Earlier revisions lack the register; it stays zero
          if (HAS_ENH) begin
            enh <= wdata;
          end
        end
        default: ;
      endcase
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    unique case (addr)
      ADDR_MON_OFS:  next_rdata = mon_ofs;
      ADDR_ANA_TRIM: next_rdata = ana_trim;
      ADDR_DAC_OFS:  next_rdata = dac_ofs;
      ADDR_CM_BAL:   next_rdata = cm_bal & MASK_CM_BAL;
      ADDR_PEAK_MON: next_rdata = peak_mon & MASK_PEAK_MON;
      ADDR_ENH_EN:   next_rdata = enh;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Calibration field outputs
  assign monitor_offset_result_a = mon_ofs[7:4];
  assign monitor_offset_result_b = mon_ofs[3:0];
  assign dac_pos_trim            = ana_trim[3];
  assign dac_neg_trim            = ana_trim[2];
  assign adc_pos_trim            = ana_trim[1];
  assign adc_neg_trim            = ana_trim[0];
  assign dac_offset_value        = dac_ofs;
  assign balance_result          = cm_bal[5:0];
  assign peak_monitor_result     = peak_mon[3:0];

  // Pin inputs synchronised
  always_ff @(posedge clk) begin
    if (rst) begin
      // Request idles high; a low reset value would drop the battery
      bat_s1 <= 1'b1;
      bat_s2 <= 1'b1;
      rel_s1 <= 1'b0;
      rel_s2 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      bat_s1 <= battery_high_req;
      bat_s2 <= bat_s1;
      rel_s1 <= tone_release;
      rel_s2 <= rel_s1;
      ext_s1 <= external_battery_select;
      ext_s2 <= ext_s1;
    end
  end

  // Boost holds from burst end until the next ring burst starts
  always_ff @(posedge clk) begin
    if (rst) begin
      boost_on <= 1'b0;
    end else if (!enh[BIT_PROGRAMMED_CURRENT_LIMIT_BOOST]) begin
      boost_on <= 1'b0;
    end else if (ring_burst_end) begin
      boost_on <= 1'b1;
    end else if (ring_active) begin
      boost_on <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_current_limit <= 6'h00;
    end else begin
      active_current_limit <= boost_on ? BOOST_LIMIT_MA
                                       : programmed_current_limit;
    end
  end

  // Fast tone clock and FSK register select share one condition
  always_ff @(posedge clk) begin
    if (rst) begin
      tone1_fast               <= 1'b0;
      tone1_oscillator_fsk_sel <= 1'b0;
    end else begin
      tone1_fast               <= enh[BIT_FSK] & rel_s2;
      tone1_oscillator_fsk_sel <= enh[BIT_FSK] & rel_s2;
    end
  end

  // The timers count on this tick, so 24 kHz gives 41.67 us steps
  tone_rate_gen u_tone (
    .clk  (clk),
    .rst  (rst),
    .fast (tone1_fast),
    .tick (tone1_tick)
  );

  // Plain feature enables
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_speedup     <= 1'b0;
      impedance_ref_disable <= 1'b0;
      voltage_loop_closure  <= 1'b0;
      converter_squelch     <= 1'b0;
      closure_hysteresis_on <= 1'b0;
    end else begin
      converter_speedup     <= HAS_DCDC & enh[BIT_SPEEDUP];
      impedance_ref_disable <= enh[BIT_ZREF];
      voltage_loop_closure  <= enh[BIT_LCV];
      converter_squelch     <= HAS_DCDC & enh[BIT_SQUELCH];
      closure_hysteresis_on <= enh[BIT_HYST];
    end
  end

  // Only a high-to-low switch waits; a return to high is immediate
  always_ff @(posedge clk) begin
    if (rst) begin
      battery_high_sel <= 1'b1;
      deb_count        <= 21'h00000;
    end else if (bat_s2 || !(enh[BIT_BATTERY_SWITCH_DEBOUNCE] && ext_s2 && !HAS_DCDC)) begin
      battery_high_sel <= bat_s2;
      deb_count        <= 21'h00000;
    end else if (battery_high_sel) begin
      if (deb_count >= 21'(DEBOUNCE_LEN - 1)) begin
        battery_high_sel <= 1'b0;
        deb_count        <= 21'h00000;
      end else begin
        deb_count <= deb_count + 21'h00001;
      end
    end
  end

  // Rate check helper: cycles since the last tick, trusted only once a
  // whole period has run at one rate
  logic [11:0] tick_gap;
  logic        fast_seen;
  logic        gap_valid;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_gap  <= 12'h000;
      fast_seen <= 1'b0;
      gap_valid <= 1'b0;
    end else begin
      fast_seen <= tone1_fast;
      if (tone1_tick || tone1_fast != fast_seen) begin
        tick_gap <= 12'h000;
      end else begin
        tick_gap <= tick_gap + 12'h001;
      end
      if (tone1_fast != fast_seen) begin
        gap_valid <= 1'b0;
      end else if (tone1_tick) begin
        gap_valid <= 1'b1;
      end
    end
  end

  // Checks
  a_reserved_bal_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == ADDR_CM_BAL |=> rdata[7:6] == 2'b00)
    else $error("balance reserved bits not zero");
  a_reserved_peak_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == ADDR_PEAK_MON |=> rdata[7:4] == 4'h0)
    else $error("peak monitor reserved bits not zero");
  a_reserved_trim_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == ADDR_ANA_TRIM |=> rdata[7:4] == 4'h0)
    else $error("trim reserved bits not zero");
  a_dac_write_read: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_DAC_OFS ##1 !wr ##1 rd && addr == ADDR_DAC_OFS
    |=> rdata == $past(wdata, 3))
    else $error("dac offset readback mismatch");
  a_mon_nibbles: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_MON_OFS |=> monitor_offset_result_a
    == $past(wdata[7:4]) && monitor_offset_result_b == $past(wdata[3:0]))
    else $error("monitor nibbles wrong");
  a_trim_bits: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ANA_TRIM |=> {dac_pos_trim, dac_neg_trim,
    adc_pos_trim, adc_neg_trim} == $past(wdata[3:0]))
    else $error("trim bits wrong");
  a_dac_field: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_DAC_OFS |=> dac_offset_value == $past(wdata))
    else $error("dac offset field wrong");
  a_bal_field: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_CM_BAL |=> balance_result == $past(wdata[5:0]))
    else $error("balance field wrong");
  a_peak_field: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_PEAK_MON |=> peak_monitor_result == $past(wdata[3:0]))
    else $error("peak monitor field wrong");
  a_boost_limit: assert property (@(posedge clk) disable iff (rst)
    enh[BIT_PROGRAMMED_CURRENT_LIMIT_BOOST] && ring_burst_end |=> ##1
    active_current_limit == BOOST_LIMIT_MA)
    else $error("boost limit not applied");
  a_boost_gated: assert property (@(posedge clk) disable iff (rst)
    !enh[BIT_PROGRAMMED_CURRENT_LIMIT_BOOST] |=> !boost_on)
    else $error("boost active while disabled");
  a_plain_limit: assert property (@(posedge clk) disable iff (rst)
    !boost_on |=> active_current_limit == $past(programmed_current_limit))
    else $error("programmed limit not applied");
  a_fast_tone: assert property (@(posedge clk) disable iff (rst)
    tone1_fast == $past(enh[BIT_FSK] & rel_s2))
    else $error("tone rate select wrong");
  a_tick_period: assert property (@(posedge clk) disable iff (rst)
    tone1_tick && gap_valid |-> tick_gap == (fast_seen
    ? 12'(TONE_FAST_DIV - 1) : 12'(TONE_SLOW_DIV - 1)))
    else $error("tone tick period wrong");
  a_fsk_select: assert property (@(posedge clk) disable iff (rst)
    tone1_oscillator_fsk_sel == tone1_fast)
    else $error("fsk register select mismatch");
  a_fsk_gated: assert property (@(posedge clk) disable iff (rst)
    !enh[BIT_FSK] |=> !tone1_oscillator_fsk_sel)
    else $error("fsk registers selected while disabled");
  a_speedup_copy: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ENH_EN ##1 1'b1 |=> converter_speedup
    == (HAS_DCDC && $past(wdata[BIT_SPEEDUP], 2)))
    else $error("converter speedup wrong");
  a_zref_copy: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ENH_EN ##1 1'b1 |=> impedance_ref_disable
    == $past(wdata[BIT_ZREF], 2))
    else $error("impedance reference control wrong");
  a_loop_basis: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ENH_EN ##1 1'b1 |=> voltage_loop_closure
    == $past(wdata[BIT_LCV], 2))
    else $error("loop closure basis wrong");
  a_squelch_copy: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ENH_EN ##1 1'b1 |=> converter_squelch
    == (HAS_DCDC && $past(wdata[BIT_SQUELCH], 2)))
    else $error("converter squelch wrong");
  a_hyst_copy: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_ENH_EN ##1 1'b1 |=> closure_hysteresis_on
    == $past(wdata[BIT_HYST], 2))
    else $error("loop closure hysteresis wrong");
  a_enh_reset: assert property (@(posedge clk)
    $past(rst) |-> enh == 8'h00)
    else $error("enhancement register not reset");
  a_no_debounce: assert property (@(posedge clk) disable iff (rst)
    !enh[BIT_BATTERY_SWITCH_DEBOUNCE] && !bat_s2 |=> !battery_high_sel)
    else $error("unexpected battery debounce");
  a_battery_rise: assert property (@(posedge clk) disable iff (rst)
    bat_s2 |=> battery_high_sel)
    else $error("return to high battery delayed");
  c_boost: cover property (@(posedge clk) disable iff (rst)
    boost_on ##1 ring_active);
  c_fast_tick: cover property (@(posedge clk) disable iff (rst)
    tone1_fast && tone1_tick);
  c_slow_tick: cover property (@(posedge clk) disable iff (rst)
    !tone1_fast && tone1_tick && gap_valid);
  c_debounce_done: cover property (@(posedge clk) disable iff (rst)
    $fell(battery_high_sel) && enh[BIT_BATTERY_SWITCH_DEBOUNCE]);
endmodule

// ---- tb/calibration_enhancement_regs_tb.sv ----
// Purpose: Self-checking bench for the calibration and enhancement registers
// Assumes: Battery-selection variant, debounce shortened to DB_LEN cycles
// Notes:   Converter bits 5 and 1 are masked on readback for this variant
module calibration_enhancement_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cal_enh_pkg::*;
  localparam int DB_LEN = 20;
  logic       clk, rst, wr, rd, ring_burst_end, ring_active, tone_release;
  logic       external_battery_select, battery_high_req;
  logic [7:0] addr, wdata, rdata, dac_offset_value, d;
  logic [5:0] programmed_current_limit, active_current_limit, balance_result;
  logic [3:0] monitor_offset_result_a, monitor_offset_result_b;
  logic [3:0] peak_monitor_result;
  logic       dac_pos_trim, dac_neg_trim, adc_pos_trim, adc_neg_trim;
  logic       tone1_tick, tone1_fast, tone1_oscillator_fsk_sel;
  logic       converter_speedup, impedance_ref_disable, voltage_loop_closure;
  logic       converter_squelch, closure_hysteresis_on, battery_high_sel;
  int         error_cnt, cmp_count, cyc;
  logic [31:0] seed;
  logic [7:0]  sh [6];

  calibration_enhancement_regs #(.DEBOUNCE_LEN(DB_LEN), .HAS_ENH(1'b1),
    .HAS_DCDC(1'b0)) i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ring_burst_end(ring_burst_end),
    .ring_active(ring_active),
    .programmed_current_limit(programmed_current_limit),
    .tone_release(tone_release),
    .external_battery_select(external_battery_select),
    .battery_high_req(battery_high_req),
    .monitor_offset_result_a(monitor_offset_result_a),
    .monitor_offset_result_b(monitor_offset_result_b),
    .dac_pos_trim(dac_pos_trim), .dac_neg_trim(dac_neg_trim),
    .adc_pos_trim(adc_pos_trim), .adc_neg_trim(adc_neg_trim),
    .dac_offset_value(dac_offset_value), .balance_result(balance_result),
    .peak_monitor_result(peak_monitor_result),
    .active_current_limit(active_current_limit), .tone1_tick(tone1_tick),
    .tone1_fast(tone1_fast),
    .tone1_oscillator_fsk_sel(tone1_oscillator_fsk_sel),
    .converter_speedup(converter_speedup),
    .impedance_ref_disable(impedance_ref_disable),
    .voltage_loop_closure(voltage_loop_closure),
    .converter_squelch(converter_squelch),
    .closure_hysteresis_on(closure_hysteresis_on),
    .battery_high_sel(battery_high_sel));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      ADDR_ANA_TRIM: return MASK_ANA_TRIM;
      ADDR_CM_BAL:   return MASK_CM_BAL;
      ADDR_PEAK_MON: return MASK_PEAK_MON;
      default:       return 8'hff;
    endcase
  endfunction

  // Field outputs gathered back into register layout
  function automatic logic [7:0] fld(input logic [7:0] a);
    case (a)
      ADDR_MON_OFS:  return {monitor_offset_result_a, monitor_offset_result_b};
      ADDR_ANA_TRIM: return {4'h0, dac_pos_trim, dac_neg_trim,
                             adc_pos_trim, adc_neg_trim};
      ADDR_DAC_OFS:  return dac_offset_value;
      ADDR_CM_BAL:   return {2'b00, balance_result};
      default:       return {4'h0, peak_monitor_result};
    endcase
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A spare cycle after each strobe keeps one assignment per time step;
  // the step past the edge lets the field outputs settle before a check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic read_all;
    for (int i = 0; i < 6; i++) begin
      rd_reg(ADDR_MON_OFS + 8'(i));
      chk("rdata", sh[i], d);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic per_chk(input int e);
    int n;
    n = 0;
    while (tone1_tick !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tone1_tick !== 1'b1 && n < 3000);
    chk("tick_period", e[15:0], n[15:0]);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  initial begin
    logic [7:0] a;
    logic [7:0] v;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ring_burst_end = 1'b0;
    ring_active = 1'b0;
    tone_release = 1'b0;
    external_battery_select = 1'b1;
    battery_high_req = 1'b1;
    programmed_current_limit = 6'h14;
    seed = 32'hca91;
    sh = '{RST_MON_OFS, RST_ANA_TRIM, RST_DAC_OFS, RST_CM_BAL,
           RST_PEAK_MON, RST_ENH_EN};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    read_all;
    // First five passes write all ones so reserved bits must drop out
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      a = seed[15:8];
      if (a >= ADDR_MON_OFS && a <= ADDR_ENH_EN) a = a ^ 8'h80;
      if (seed[3]) a = ADDR_MON_OFS + 8'(seed[2:0] % 5);
      v = seed[23:16];
      if (i < 5) begin
        a = ADDR_MON_OFS + 8'(i);
        v = 8'hff;
      end
      wr_reg(a, v);
      if (a >= ADDR_MON_OFS && a < ADDR_ENH_EN) begin
        sh[a - ADDR_MON_OFS] = v & msk(a);
        chk("field", sh[a - ADDR_MON_OFS], fld(a));
        rd_reg(a);
        chk("rdata", sh[a - ADDR_MON_OFS], d);
      end else begin
        rd_reg(a);
        chk("unmapped", 8'h00, d);
      end
    end
    read_all;
    seed = xs(seed);
    programmed_current_limit <= (seed[5:0] == BOOST_LIMIT_MA) ? 6'h10
                                                               : seed[5:0];
    wr_reg(ADDR_ENH_EN, 8'hff);
    wait_cyc(3);
    chk("loop_voltage", 1, voltage_loop_closure);
    chk("zref_off", 1, impedance_ref_disable);
    chk("hyst", 1, closure_hysteresis_on);
    chk("speedup", 0, converter_speedup);
    chk("squelch", 0, converter_squelch);
    chk("fast_no_rel", 0, tone1_fast);
    chk("limit", programmed_current_limit, active_current_limit);
    rd_reg(ADDR_ENH_EN);
    chk("enh_rd", 8'hdd, d & 8'hdd);
    @(posedge clk) ring_burst_end <= 1'b1;
    @(posedge clk) ring_burst_end <= 1'b0;
    wait_cyc(2);
    chk("boost", BOOST_LIMIT_MA, active_current_limit);
    @(posedge clk) ring_active <= 1'b1;
    wait_cyc(3);
    chk("boost_end", programmed_current_limit, active_current_limit);
    @(posedge clk) ring_active <= 1'b0;
    per_chk(TONE_SLOW_DIV);
    @(posedge clk) tone_release <= 1'b1;
    wait_cyc(10);
    chk("fast", 1, tone1_fast);
    chk("fsk_sel", 1, tone1_oscillator_fsk_sel);
    per_chk(TONE_FAST_DIV);
    @(posedge clk) battery_high_req <= 1'b0;
    wait_cyc(10);
    chk("bat_hold", 1, battery_high_sel);
    wait_cyc(30);
    chk("bat_low", 0, battery_high_sel);
    @(posedge clk) battery_high_req <= 1'b1;
    wait_cyc(6);
    chk("bat_high", 1, battery_high_sel);
    wr_reg(ADDR_ENH_EN, 8'h00);
    wait_cyc(3);
    chk("fast_off", 0, tone1_fast);
    chk("fsk_off", 0, tone1_oscillator_fsk_sel);
    chk("loop_current", 0, voltage_loop_closure);
    chk("zref_on", 0, impedance_ref_disable);
    chk("hyst_off", 0, closure_hysteresis_on);
    per_chk(TONE_SLOW_DIV);
    @(posedge clk) battery_high_req <= 1'b0;
    wait_cyc(6);
    chk("bat_nodb", 0, battery_high_sel);
    @(posedge clk) ring_burst_end <= 1'b1;
    @(posedge clk) ring_burst_end <= 1'b0;
    wait_cyc(3);
    chk("no_boost", programmed_current_limit, active_current_limit);
    report_and_stop;
  end
endmodule
